// file: ops_exec.sv
// execution unit for swap, zero-skip, table-read and exclusive-or operations
// assumes data memory read data is combinational on mem_rdata_i for instr_i.addr
`timescale 1ns/10ps
`include "ops_params.svh"
// What this block does
// - swap operand nibbles into working register
// - skip next instruction when byte zero
// - skip adds dummy cycle, two cycles
// - copy byte to working, skip if zero
// - skip when selected bit is zero
// - current page table read, split bytes
// - last page table read, split bytes
// - xor memory into working register
// - xor into memory, working unchanged
// - xor immediate into working register
module ops_exec
  import ops_pkg::*;
(
  input  wire logic                sys_clk_i,
  input  wire logic                rstn_i,
  input  wire logic                valid_i,
  input  wire instr_t              instr_i,
  input  wire logic [`PC_W-1:0]    pc_i,
  input  wire logic [`DATA_W-1:0]  mem_rdata_i,
  input  wire logic                rom_we_i,
  input  wire logic [`PC_W-1:0]    rom_waddr_i,
  input  wire logic [`PROG_W-1:0]  rom_wdata_i,
  output logic                     ready_o,
  output mem_wr_t                  mem_wr_o,
  output logic [`DATA_W-1:0]       working_o,
  output logic [`DATA_W-1:0]       table_pointer_o,
  output logic [`PROG_W-`DATA_W-1:0] table_high_latch_o,
  output logic                     result_null_flag_o,
  output logic                     skip_o,
  output logic                     dummy_o
);
  typedef enum logic [1:0] {S_RUN, S_TAB, S_DUMMY} st_t;
  st_t st_q;

  logic [`DATA_W-1:0] work_q, tptr_q, xor_v;
  logic [`PROG_W-`DATA_W-1:0] thigh_q;
  logic               zflag_q, skip_q;
  logic [`ADDR_W-1:0] tab_dst_q;
  logic [`PC_W-1:0]   rom_addr;
  logic [`PROG_W-1:0] rom_data;
  logic               take, skip_now;

  function automatic logic is_xor(input op_t op);
    return op == OP_XOR_WORK || op == OP_XOR_MEM || op == OP_XOR_IMM;
  endfunction : is_xor

  assign take    = valid_i && st_q == S_RUN;
  assign ready_o = st_q == S_RUN;
  assign xor_v   = work_q ^ ((instr_i.op == OP_XOR_IMM) ? instr_i.imm : mem_rdata_i);

  // skip decisions
  always_comb
  begin
    unique case (instr_i.op)
      OP_SKIP_NULL: skip_now = mem_rdata_i == 8'h00;
      OP_COPY_SKIP: skip_now = mem_rdata_i == 8'h00;
      OP_BIT_SKIP:  skip_now = !mem_rdata_i[instr_i.bit_sel];
      default:      skip_now = 1'b0;
    endcase
  end

  always_comb
  begin
    if (instr_i.op == OP_TAB_LAST)
      rom_addr = {`LAST_PAGE, tptr_q};
    else
      rom_addr = {pc_i[`PC_W-1:`DATA_W], tptr_q};
  end

  table_rom #(.AW(`PC_W), .DW(`PROG_W)) u_rom (
    .sys_clk_i (sys_clk_i),
    .addr_i    (rom_addr),
    .we_i      (rom_we_i),
    .waddr_i   (rom_waddr_i),
    .wdata_i   (rom_wdata_i),
    .rdata_o   (rom_data)
  );

  // sequencing: table read waits for rom, skip inserts dummy
  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
      st_q <= S_RUN;
    else
    begin
      unique case (st_q)
        S_RUN:
          if (take && (instr_i.op == OP_TAB_CUR || instr_i.op == OP_TAB_LAST))
            st_q <= S_TAB;
          else if (take && skip_now)
            st_q <= S_DUMMY;
        S_TAB:   st_q <= S_RUN;
        S_DUMMY: st_q <= S_RUN;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
      tab_dst_q <= '0;
    else if (take)
      tab_dst_q <= instr_i.addr;
  end

  // working register updates
  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
      work_q <= `WORK_RST;
    else if (take)
    begin
      unique case (instr_i.op)
        OP_SWAP_WORK: work_q <= {mem_rdata_i[3:0], mem_rdata_i[7:4]};
        OP_COPY_SKIP: work_q <= mem_rdata_i;
        OP_XOR_WORK: work_q <= xor_v;
        OP_XOR_IMM: work_q <= xor_v;
        default: work_q <= work_q;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
      zflag_q <= 1'b0;
    else if (take && is_xor(instr_i.op))
      zflag_q <= xor_v == 8'h00;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
      tptr_q <= `TPTR_RST;
    else if (take && instr_i.op == OP_SET_TPTR)
      tptr_q <= instr_i.imm;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
      thigh_q <= `THIGH_RST;
    else if (st_q == S_TAB)
      thigh_q <= rom_data[`PROG_W-1:`DATA_W];
  end

  // memory write port
  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
      mem_wr_o <= '0;
    else if (st_q == S_TAB)
      mem_wr_o <= '{we: 1'b1, addr: tab_dst_q, wdata: rom_data[`DATA_W-1:0]};
    else if (take && instr_i.op == OP_XOR_MEM)
      mem_wr_o <= '{we: 1'b1, addr: instr_i.addr, wdata: xor_v};
    else
      mem_wr_o <= '0;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
      skip_q <= 1'b0;
    else
      skip_q <= take && skip_now;
  end

  assign working_o          = work_q;
  assign table_pointer_o    = tptr_q;
  assign table_high_latch_o = thigh_q;
  assign result_null_flag_o = zflag_q;
  assign skip_o             = skip_q;
  assign dummy_o            = st_q == S_DUMMY;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  sequence skip_taken_s;
    take && skip_now;
  endsequence
  sequence dummy_cycle_s;
    dummy_o ##1 ready_o;
  endsequence

  swap_result_a: assert property (take && instr_i.op == OP_SWAP_WORK |=>
    work_q == {$past(mem_rdata_i[3:0]), $past(mem_rdata_i[7:4])})
    else $error("swap result wrong");
  null_skip_a: assert property (take && instr_i.op == OP_SKIP_NULL |=>
    skip_o == ($past(mem_rdata_i) == 8'h00))
    else $error("null skip wrong");
  two_cycle_a: assert property (skip_taken_s |=> dummy_cycle_s)
    else $error("skip not two cycles");
  copy_skip_a: assert property (take && instr_i.op == OP_COPY_SKIP |=>
    work_q == $past(mem_rdata_i) && skip_o == (work_q == 8'h00))
    else $error("copy skip wrong");
  bit_skip_a: assert property (take && instr_i.op == OP_BIT_SKIP |=>
    skip_o == !$past(mem_rdata_i[instr_i.bit_sel]))
    else $error("bit skip wrong");
  tab_cur_a: assert property (take && instr_i.op == OP_TAB_CUR |=> ##1
    mem_wr_o.we && mem_wr_o.addr == $past(instr_i.addr, 2))
    else $error("table read write missing");
  tab_last_a: assert property (take && instr_i.op == OP_TAB_LAST |->
    rom_addr[`PC_W-1:`DATA_W] == `LAST_PAGE)
    else $error("last page address wrong");
  xor_work_a: assert property (take && instr_i.op == OP_XOR_WORK |=>
    work_q == ($past(work_q) ^ $past(mem_rdata_i)))
    else $error("xor to working wrong");
  xor_mem_a: assert property (take && instr_i.op == OP_XOR_MEM |=>
    mem_wr_o.we && $stable(work_q) && mem_wr_o.wdata == ($past(work_q) ^ $past(mem_rdata_i)))
    else $error("xor to memory wrong");
  xor_imm_a: assert property (take && instr_i.op == OP_XOR_IMM |=>
    work_q == ($past(work_q) ^ $past(instr_i.imm)))
    else $error("xor immediate wrong");
  null_flag_a: assert property (take && is_xor(instr_i.op) |=>
    result_null_flag_o == ($past(xor_v) == 8'h00))
    else $error("null flag wrong");
endmodule : ops_exec

// file: ops_params.svh
// widths, last page, reset values and counts for the skip/swap/xor/table-read unit
// assumes inclusion by the package and the execution unit
`ifndef OPS_PARAMS_SVH
`define OPS_PARAMS_SVH
`define DATA_W       8
`define ADDR_W       9
`define PROG_W       15
`define PC_W         12
`define PAGE_W       4
`define LAST_PAGE    4'hF
`define WORK_RST     8'h00
`define TPTR_RST     8'h00
`define THIGH_RST    7'h00
`define SKIP_CYCLES  2
`endif

// file: ops_pkg.sv
// types for the skip/swap/xor/table-read execution unit
// assumes ops_params.svh is in the include path
`include "ops_params.svh"
package ops_pkg;
  typedef enum logic [3:0] {
    OP_NOP,
    OP_SWAP_WORK,
    OP_SKIP_NULL,
    OP_COPY_SKIP,
    OP_BIT_SKIP,
    OP_TAB_CUR,
    OP_TAB_LAST,
    OP_XOR_WORK,
    OP_XOR_MEM,
    OP_XOR_IMM,
    OP_SET_TPTR
  } op_t;

  typedef struct packed {
    op_t                 op;
    logic [`ADDR_W-1:0]  addr;
    logic [2:0]          bit_sel;
    logic [`DATA_W-1:0]  imm;
  } instr_t;

  typedef struct packed {
    logic                we;
    logic [`ADDR_W-1:0]  addr;
    logic [`DATA_W-1:0]  wdata;
  } mem_wr_t;
endpackage : ops_pkg

// file: table_rom.sv
// program memory holding table words, registered read
// assumes one clock, read data one cycle after the address
`timescale 1ns/10ps
module table_rom #(
  parameter int AW = 12,
  parameter int DW = 15
) (
  input  wire logic          sys_clk_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [DW-1:0] wdata_i,
  output logic      [DW-1:0] rdata_o
);
  logic [DW-1:0] mem_q [0:(1<<AW)-1];

  // loading port for program words
  always_ff @(posedge sys_clk_i)
  begin
    if (we_i)
      mem_q[waddr_i] <= wdata_i;
  end

  always_ff @(posedge sys_clk_i)
  begin
    rdata_o <= mem_q[addr_i];
  end
endmodule : table_rom

// file: data_mem.sv
// data memory model on the far side of the unit
// assumes combinational read, write on clock edge
`timescale 1ns/10ps
`include "ops_params.svh"
module data_mem
  import ops_pkg::*;
(
  input  wire logic               sys_clk_i,
  input  wire logic [`ADDR_W-1:0] raddr_i,
  input  wire mem_wr_t            wr_i,
  input  wire mem_wr_t            ld_i,
  output logic      [`DATA_W-1:0] rdata_o
);
  logic [`DATA_W-1:0] ram [512];
  assign rdata_o = ram[raddr_i];
  always_ff @(posedge sys_clk_i)
  begin
    if (ld_i.we)
      ram[ld_i.addr] <= ld_i.wdata;
    else if (wr_i.we)
      ram[wr_i.addr] <= wr_i.wdata;
  end
endmodule : data_mem

// file: mcu_skip_swap_xor_tableread_ops_tb_top.sv
// testbench for the execution unit
// assumes data_mem as memory model
`timescale 1ns/10ps
`include "ops_params.svh"
module mcu_skip_swap_xor_tableread_ops_tb_top;
  import ops_pkg::*;
  logic        sys_clk_i, rstn_i, valid_i, rom_we_i;
  logic        ready_o, result_null_flag_o, skip_o, dummy_o;
  instr_t      instr_i;
  mem_wr_t     mem_wr_o;
  mem_wr_t     ld_i;
  logic [11:0] pc_i, rom_waddr_i;
  logic [14:0] rom_wdata_i;
  logic [7:0]  mem_rdata_i, working_o, table_pointer_o;
  logic [6:0]  table_high_latch_o;
  int          n_fail = 0;
  int          comparisons = 0;
  ops_exec dut (.sys_clk_i, .rstn_i, .valid_i, .instr_i, .pc_i, .mem_rdata_i,
    .rom_we_i, .rom_waddr_i, .rom_wdata_i, .ready_o, .mem_wr_o, .working_o,
    .table_pointer_o, .table_high_latch_o, .result_null_flag_o, .skip_o, .dummy_o);
  data_mem mem (.sys_clk_i, .raddr_i(instr_i.addr), .wr_i(mem_wr_o), .ld_i,
    .rdata_o(mem_rdata_i));
  task automatic stop_test();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chk_bit(input string nm, input logic e, input logic g);
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit
  // preload one data memory byte through the load port
  task automatic put(input logic [8:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    ld_i = '{1'b1, a, d};
    @(negedge sys_clk_i);
    ld_i = '0;
  endtask : put
  // offer one instruction at a falling edge once ready
  task automatic op(input op_t o, input logic [8:0] a, input logic [2:0] b,
                    input logic [7:0] i);
    int k;
    k = 0;
    @(negedge sys_clk_i);
    while (ready_o !== 1'b1 && k < 8)
    begin
      @(negedge sys_clk_i);
      k++;
    end
    if (k == 8)
    begin
      n_fail++;
      stop_test();
    end
    else
    begin
      valid_i = 1'b1;
      instr_i = '{o, a, b, i};
      @(negedge sys_clk_i);
      valid_i = 1'b0;
    end
  endtask : op
  task automatic sc_skip();
    put(9'h020, 8'h00);
    put(9'h021, 8'h01);
    op(OP_SKIP_NULL, 9'h020, 3'h0, 8'h00);
    chk_bit("skip", 1'b1, skip_o);
    chk_bit("dummy", 1'b1, dummy_o);
    chk_bit("ready", 1'b0, ready_o);
    @(negedge sys_clk_i);
    chk_bit("ready", 1'b1, ready_o);
    op(OP_SKIP_NULL, 9'h021, 3'h0, 8'h00);
    chk_bit("skip", 1'b0, skip_o);
  endtask : sc_skip
  task automatic sc_copy_bit();
    put(9'h031, 8'h80);
    put(9'h030, 8'h00);
    put(9'h040, 8'hFB);
    op(OP_COPY_SKIP, 9'h031, 3'h0, 8'h00);
    chk("working", 8'h80, working_o);
    chk_bit("skip", 1'b0, skip_o);
    op(OP_COPY_SKIP, 9'h030, 3'h0, 8'h00);
    chk("working", 8'h00, working_o);
    chk_bit("skip", 1'b1, skip_o);
    op(OP_BIT_SKIP, 9'h040, 3'h2, 8'h00);
    chk_bit("skip", 1'b1, skip_o);
    op(OP_BIT_SKIP, 9'h040, 3'h3, 8'h00);
    chk_bit("skip", 1'b0, skip_o);
  endtask : sc_copy_bit
  task automatic sc_table();
    rom_we_i = 1'b1;
    rom_waddr_i = 12'h255;
    rom_wdata_i = 15'h5AA5;
    @(negedge sys_clk_i);
    rom_waddr_i = 12'hF55;
    rom_wdata_i = 15'h1234;
    @(negedge sys_clk_i);
    rom_we_i = 1'b0;
    pc_i = 12'h2A0;
    op(OP_SET_TPTR, 9'h000, 3'h0, 8'h55);
    chk("pointer", 8'h55, table_pointer_o);
    op(OP_TAB_CUR, 9'h050, 3'h0, 8'h00);
    repeat (2) @(negedge sys_clk_i);
    chk("latch", 8'h5A, {1'b0, table_high_latch_o});
    chk("memory", 8'hA5, mem.ram[9'h050]);
    op(OP_TAB_LAST, 9'h051, 3'h0, 8'h00);
    repeat (2) @(negedge sys_clk_i);
    chk("latch", 8'h12, {1'b0, table_high_latch_o});
    chk("memory", 8'h34, mem.ram[9'h051]);
  endtask : sc_table
  task automatic sc_xor_swap();
    put(9'h061, 8'h0F);
    put(9'h062, 8'hAA);
    put(9'h010, 8'h3C);
    op(OP_XOR_WORK, 9'h061, 3'h0, 8'h00);
    chk("working", 8'h0F, working_o);
    chk_bit("flag", 1'b0, result_null_flag_o);
    op(OP_XOR_IMM, 9'h000, 3'h0, 8'h0F);
    chk("working", 8'h00, working_o);
    chk_bit("flag", 1'b1, result_null_flag_o);
    op(OP_SWAP_WORK, 9'h010, 3'h0, 8'h00);
    chk("working", 8'hC3, working_o);
    chk_bit("flag", 1'b1, result_null_flag_o);
    op(OP_XOR_MEM, 9'h062, 3'h0, 8'h00);
    @(negedge sys_clk_i);
    chk("memory", 8'h69, mem.ram[9'h062]);
    chk("working", 8'hC3, working_o);
    chk_bit("flag", 1'b0, result_null_flag_o);
    chk("memory", 8'h3C, mem.ram[9'h010]);
  endtask : sc_xor_swap
  initial
  begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  initial
  begin
    rstn_i = 1'b0;
    valid_i = 1'b0;
    instr_i = '0;
    ld_i = '0;
    pc_i = 12'h000;
    rom_we_i = 1'b0;
    rom_waddr_i = 12'h000;
    rom_wdata_i = 15'h0000;
    repeat (20) @(negedge sys_clk_i);
    rstn_i = 1'b1;
    chk("working", 8'h00, working_o);
    sc_skip();
    sc_copy_bit();
    sc_table();
    sc_xor_swap();
    stop_test();
  end
endmodule : mcu_skip_swap_xor_tableread_ops_tb_top
